// ==== inc/sbm_defs.svh ====
`ifndef SBM_DEFS_SVH
`define SBM_DEFS_SVH
`define SBM_ADDR_W 25
`define SBM_DATA_W 16
`define SBM_CS_NUM 8
`define SBM_CS_CMP_W 8
`define SBM_CS_CMP_LSB 17
`define SBM_HI_ADDR_LSB 21
`define SBM_WAIT_W 4
`define SBM_RW_RESET 1'b1
`endif

// ==== inc/sbm_pkg.sv ====
package sbm_pkg;
  typedef enum logic [1:0] {
    SBM_PIN_OFF = 2'b00,
    SBM_PIN_INPUT = 2'b01,
    SBM_PIN_NORMAL = 2'b10,
    SBM_PIN_SPECIAL = 2'b11
  } sbm_pin_mode_e;
  typedef enum logic [2:0] {
    SBM_IDLE = 3'b000,
    SBM_ADDR = 3'b001,
    SBM_DATA = 3'b010,
    SBM_END = 3'b011,
    SBM_GRANT = 3'b100
  } sbm_dev_state_e;
  typedef enum logic [2:0] {
    SBM_H_IDLE = 3'b000,
    SBM_H_REQ = 3'b001,
    SBM_H_ADDR = 3'b010,
    SBM_H_WAIT = 3'b011,
    SBM_H_END = 3'b100
  } sbm_host_state_e;
endpackage : sbm_pkg

// ==== inc/sbm_if.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sbm_defs.svh"
interface sbm_if;
  logic [`SBM_ADDR_W-1:0] addr_dev, addr_host, addr;
  logic addr_dev_oe_lo, addr_dev_oe_hi, host_oe;
  logic [`SBM_DATA_W-1:0] data_dev, data_host, data;
  logic data_dev_oe, data_host_oe;
  logic as_n_dev, as_dev_oe, as_n_host, as_n;
  logic rw_dev, rw_dev_oe, rw_host, rw;
  logic uds_n_host, lds_n_host, uds_n, lds_n;
  logic br_n_host, br_n;
  logic bg_n_dev, ext_ack_n_dev, rd_n_dev, wru_n_dev, wrl_n_dev, out_oe;
  logic [`SBM_CS_NUM-1:0] cs_n_dev, cs_n;
  logic bg_n, ext_ack_n, rd_n, wru_n, wrl_n;
  logic wait_n, high_impedance_select, test, sys_reset_n, half_rate_clock;
  logic [1:0] irq_n;
  localparam int LO = `SBM_HI_ADDR_LSB;
  // undriven lines float high through pull-ups
  assign addr[LO-1:0] = addr_dev_oe_lo ? addr_dev[LO-1:0] :
                        host_oe ? addr_host[LO-1:0] : '1;
  assign addr[`SBM_ADDR_W-1:LO] = addr_dev_oe_hi ? addr_dev[`SBM_ADDR_W-1:LO] :
                        host_oe ? addr_host[`SBM_ADDR_W-1:LO] : '1;
  assign data = data_dev_oe ? data_dev : data_host_oe ? data_host : '1;
  assign as_n = as_dev_oe ? as_n_dev : host_oe ? as_n_host : 1'b1;
  assign rw = rw_dev_oe ? rw_dev : host_oe ? rw_host : 1'b1;
  assign uds_n = host_oe ? uds_n_host : 1'b1;
  assign lds_n = host_oe ? lds_n_host : 1'b1;
  assign br_n = br_n_host;
  assign bg_n = out_oe ? bg_n_dev : 1'b1;
  assign ext_ack_n = out_oe ? ext_ack_n_dev : 1'b1;
  assign rd_n = out_oe ? rd_n_dev : 1'b1;
  assign wru_n = out_oe ? wru_n_dev : 1'b1;
  assign wrl_n = out_oe ? wrl_n_dev : 1'b1;
  assign cs_n = out_oe ? cs_n_dev : '1;
  modport dev (
    output addr_dev, addr_dev_oe_lo, addr_dev_oe_hi, data_dev, data_dev_oe,
    output as_n_dev, as_dev_oe, rw_dev, rw_dev_oe, bg_n_dev, ext_ack_n_dev,
    output cs_n_dev, rd_n_dev, wru_n_dev, wrl_n_dev, out_oe,
    input addr, data, as_n, rw, uds_n, lds_n, br_n, wait_n, irq_n,
    input high_impedance_select, test, sys_reset_n
  );
  modport host (
    output addr_host, host_oe, data_host, data_host_oe, as_n_host, rw_host,
    output uds_n_host, lds_n_host, br_n_host, wait_n, irq_n,
    output high_impedance_select, test, sys_reset_n, half_rate_clock,
    input addr, data, as_n, rw, bg_n, ext_ack_n, cs_n, rd_n, wru_n, wrl_n
  );
endinterface : sbm_if
`default_nettype wire

// ==== src/sbm_device.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sbm_defs.svh"
module sbm_device (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  sbm_if.dev bus,
  input wire logic i_req,
  input wire logic i_req_rw,
  input wire logic [`SBM_ADDR_W-1:0] i_req_addr,
  input wire logic [1:0] i_req_be,
  input wire logic [`SBM_DATA_W-1:0] i_req_wdata,
  output logic o_req_done,
  output logic [`SBM_DATA_W-1:0] o_req_rdata,
  input wire logic [`SBM_CS_NUM-1:0] i_cs_en,
  input wire logic [`SBM_CS_NUM*`SBM_CS_CMP_W-1:0] i_cs_base,
  input wire logic [`SBM_CS_NUM*`SBM_CS_CMP_W-1:0] i_cs_mask,
  input wire logic [`SBM_CS_NUM*`SBM_WAIT_W-1:0] i_cs_wait,
  input wire logic [1:0] i_irq_level,
  output logic [1:0] o_irq_pending,
  output logic o_half_rate_en,
  output logic o_ext_master,
  output logic [`SBM_ADDR_W-1:0] o_ext_addr,
  output logic [1:0] o_ext_be,
  output logic [`SBM_DATA_W-1:0] o_ext_wdata,
  output logic o_ext_wr,
  input wire logic [`SBM_DATA_W-1:0] i_ext_rdata
);
  localparam int NCS = `SBM_CS_NUM;
  localparam int CW = `SBM_CS_CMP_W;
  localparam int WW = `SBM_WAIT_W;
  localparam int CL = `SBM_CS_CMP_LSB;

  sbm_pkg::sbm_pin_mode_e pin_mode;
  sbm_pkg::sbm_dev_state_e state;
  logic all_off, hi_off, ph, rst_q, sync_rst;
  logic own, act, rw_cur, cs_hit, wait_hold, ext_started, ext_ack_n;
  logic rw_q, rd_n, wru_n, wrl_n;
  logic [1:0] be_q, be_cur;
  logic [`SBM_ADDR_W-1:0] addr_q, cur_addr;
  logic [`SBM_DATA_W-1:0] wdata_q, data_q;
  logic [WW-1:0] cnt, ecnt, wait_sel;
  logic [NCS-1:0] hit, cs_n;
  logic [WW-1:0] wait_m [NCS];

  assign pin_mode = sbm_pkg::sbm_pin_mode_e'({bus.high_impedance_select,
                                              bus.test});
  assign all_off = (pin_mode == sbm_pkg::SBM_PIN_OFF);
  assign hi_off = all_off | (pin_mode == sbm_pkg::SBM_PIN_INPUT);
  assign sync_rst = ~bus.sys_reset_n;

  // half-rate phase keeps toggling; reset release realigns it
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_q <= 1'b0;
      ph <= 1'b0;
    end else begin
      rst_q <= bus.sys_reset_n;
      if (bus.sys_reset_n && !rst_q) begin
        ph <= 1'b0;
      end else begin
        ph <= ~ph;
      end
    end
  end
  assign o_half_rate_en = ph;

  assign own = (state != sbm_pkg::SBM_GRANT);
  assign o_ext_master = ~own;
  assign cur_addr = own ? addr_q : bus.addr;
  assign rw_cur = own ? rw_q : bus.rw;
  assign be_cur = own ? be_q : ~{bus.uds_n, bus.lds_n};
  assign act = own ? (state == sbm_pkg::SBM_DATA) : ~bus.as_n;

  genvar g;
  generate
    for (g = 0; g < NCS; g++) begin : g_cs
      assign hit[g] = i_cs_en[g] & (((cur_addr[CL+CW-1:CL] ^
                      i_cs_base[g*CW +: CW]) & i_cs_mask[g*CW +: CW]) ==
                      {CW{1'b0}});
      assign wait_m[g] = hit[g] ? i_cs_wait[g*WW +: WW] : {WW{1'b0}};
    end
  endgenerate

  always_comb begin
    wait_sel = {WW{1'b0}};
    for (int i = 0; i < NCS; i++) begin
      wait_sel = wait_sel | wait_m[i];
    end
  end
  assign cs_hit = |hit;
  assign wait_hold = cs_hit & ~bus.wait_n;

  // own bus cycle sequencer and arbitration
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= sbm_pkg::SBM_IDLE;
      addr_q <= {`SBM_ADDR_W{1'b0}};
      rw_q <= `SBM_RW_RESET;
      be_q <= 2'b00;
      wdata_q <= {`SBM_DATA_W{1'b0}};
      cnt <= {WW{1'b0}};
    end else if (sync_rst) begin
      state <= sbm_pkg::SBM_IDLE;
      rw_q <= `SBM_RW_RESET;
      cnt <= {WW{1'b0}};
    end else if (ph) begin
      case (state)
        sbm_pkg::SBM_IDLE: begin
          if (!bus.br_n) begin
            state <= sbm_pkg::SBM_GRANT;
          end else if (i_req) begin
            addr_q <= i_req_addr;
            rw_q <= i_req_rw;
            be_q <= i_req_be;
            wdata_q <= i_req_wdata;
            state <= sbm_pkg::SBM_ADDR;
          end
        end
        sbm_pkg::SBM_ADDR: begin
          cnt <= wait_sel;
          state <= sbm_pkg::SBM_DATA;
        end
        sbm_pkg::SBM_DATA: begin
          if (cnt != {WW{1'b0}}) begin
            cnt <= cnt - 1'b1;
          end else if (!wait_hold) begin
            state <= sbm_pkg::SBM_END;
          end
        end
        sbm_pkg::SBM_END: begin
          state <= sbm_pkg::SBM_IDLE;
        end
        sbm_pkg::SBM_GRANT: begin
          if (bus.br_n && bus.as_n) begin
            state <= sbm_pkg::SBM_IDLE;
          end
        end
        default: begin
          state <= sbm_pkg::SBM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_req_done <= 1'b0;
      o_req_rdata <= {`SBM_DATA_W{1'b0}};
    end else begin
      o_req_done <= ph & ~sync_rst & (state == sbm_pkg::SBM_DATA) &
                    (cnt == {WW{1'b0}}) & ~wait_hold;
      if (ph && state == sbm_pkg::SBM_DATA && rw_q) begin
        o_req_rdata <= bus.data;
      end
    end
  end

  // responder for cycles run by the external master
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ext_started <= 1'b0;
      ext_ack_n <= 1'b1;
      ecnt <= {WW{1'b0}};
      o_ext_wr <= 1'b0;
      o_ext_addr <= {`SBM_ADDR_W{1'b0}};
      o_ext_be <= 2'b00;
      o_ext_wdata <= {`SBM_DATA_W{1'b0}};
    end else begin
      o_ext_wr <= 1'b0;
      if (sync_rst || own || bus.as_n) begin
        ext_started <= 1'b0;
        ext_ack_n <= 1'b1;
      end else if (!ext_started) begin
        ext_started <= 1'b1;
        ecnt <= wait_sel;
        o_ext_addr <= bus.addr;
        o_ext_be <= be_cur;
      end else if (ph && ext_ack_n) begin
        if (ecnt != {WW{1'b0}}) begin
          ecnt <= ecnt - 1'b1;
        end else if (!wait_hold) begin
          ext_ack_n <= 1'b0;
          o_ext_wr <= ~bus.rw;
          o_ext_wdata <= bus.data;
        end
      end
    end
  end

  // registered pin strobes
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_n <= {NCS{1'b1}};
      rd_n <= 1'b1;
      wru_n <= 1'b1;
      wrl_n <= 1'b1;
      data_q <= {`SBM_DATA_W{1'b0}};
    end else begin
      cs_n <= ~(hit & {NCS{act}});
      rd_n <= ~(act & rw_cur);
      wru_n <= ~(act & ~rw_cur & be_cur[1]);
      wrl_n <= ~(act & ~rw_cur & be_cur[0]);
      data_q <= own ? wdata_q : i_ext_rdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq_pending <= 2'b00;
    end else begin
      o_irq_pending <= bus.irq_n ~^ i_irq_level;
    end
  end

  assign bus.out_oe = ~all_off;
  assign bus.addr_dev = addr_q;
  assign bus.addr_dev_oe_lo = own & ~all_off;
  assign bus.addr_dev_oe_hi = own & ~hi_off;
  assign bus.as_n_dev = ~((state == sbm_pkg::SBM_ADDR) |
                          (state == sbm_pkg::SBM_DATA));
  assign bus.as_dev_oe = own & ~all_off;
  assign bus.rw_dev = rw_q;
  assign bus.rw_dev_oe = own & ~all_off;
  assign bus.data_dev = data_q;
  assign bus.data_dev_oe = ~all_off & (own ?
    (((state == sbm_pkg::SBM_ADDR) | (state == sbm_pkg::SBM_DATA)) & ~rw_q) :
    (~bus.as_n & bus.rw));
  assign bus.bg_n_dev = own;
  assign bus.ext_ack_n_dev = ext_ack_n;
  assign bus.cs_n_dev = cs_n;
  assign bus.rd_n_dev = rd_n;
  assign bus.wru_n_dev = wru_n;
  assign bus.wrl_n_dev = wrl_n;
endmodule : sbm_device
`default_nettype wire

// ==== src/sbm_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sbm_defs.svh"
module sbm_host (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  sbm_if.host bus,
  input wire logic i_reset_source_n,
  input wire logic i_hiz_sel,
  input wire logic i_test,
  input wire logic i_wait_n,
  input wire logic [1:0] i_irq_n,
  input wire logic i_start,
  input wire logic i_rw,
  input wire logic [`SBM_ADDR_W-1:0] i_addr,
  input wire logic [1:0] i_be,
  input wire logic [`SBM_DATA_W-1:0] i_wdata,
  output logic o_busy,
  output logic o_done,
  output logic [`SBM_DATA_W-1:0] o_rdata
);
  sbm_pkg::sbm_host_state_e state;
  logic rst_s1, rst_s2, rst_s3, hclk, br_n, as_n, oe, rw_q;
  logic [1:0] be_q;
  logic [`SBM_ADDR_W-1:0] addr_q;
  logic [`SBM_DATA_W-1:0] wdata_q;

  // reset source double-synchronised, trailing edge realigns half clock
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
      rst_s3 <= 1'b0;
      hclk <= 1'b0;
    end else begin
      rst_s1 <= i_reset_source_n;
      rst_s2 <= rst_s1;
      rst_s3 <= rst_s2;
      if (rst_s2 && !rst_s3) begin
        hclk <= 1'b0;
      end else begin
        hclk <= ~hclk;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= sbm_pkg::SBM_H_IDLE;
      br_n <= 1'b1;
      as_n <= 1'b1;
      oe <= 1'b0;
      o_done <= 1'b0;
      rw_q <= `SBM_RW_RESET;
      be_q <= 2'b00;
      addr_q <= {`SBM_ADDR_W{1'b0}};
      wdata_q <= {`SBM_DATA_W{1'b0}};
      o_rdata <= {`SBM_DATA_W{1'b0}};
    end else if (!rst_s2) begin
      state <= sbm_pkg::SBM_H_IDLE;
      br_n <= 1'b1;
      as_n <= 1'b1;
      oe <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state)
        sbm_pkg::SBM_H_IDLE: begin
          if (i_start) begin
            rw_q <= i_rw;
            be_q <= i_be;
            addr_q <= i_addr;
            wdata_q <= i_wdata;
            br_n <= 1'b0;
            state <= sbm_pkg::SBM_H_REQ;
          end
        end
        sbm_pkg::SBM_H_REQ: begin
          if (!bus.bg_n) begin
            oe <= 1'b1;
            state <= sbm_pkg::SBM_H_ADDR;
          end
        end
        sbm_pkg::SBM_H_ADDR: begin
          as_n <= 1'b0;
          state <= sbm_pkg::SBM_H_WAIT;
        end
        sbm_pkg::SBM_H_WAIT: begin
          if (!bus.ext_ack_n) begin
            if (rw_q) begin
              o_rdata <= bus.data;
            end
            as_n <= 1'b1;
            state <= sbm_pkg::SBM_H_END;
          end
        end
        sbm_pkg::SBM_H_END: begin
          oe <= 1'b0;
          if (bus.ext_ack_n) begin
            br_n <= 1'b1;
            o_done <= 1'b1;
            state <= sbm_pkg::SBM_H_IDLE;
          end
        end
        default: begin
          state <= sbm_pkg::SBM_H_IDLE;
        end
      endcase
    end
  end

  assign o_busy = (state != sbm_pkg::SBM_H_IDLE);
  assign bus.sys_reset_n = rst_s2;
  assign bus.half_rate_clock = hclk;
  assign bus.br_n_host = br_n;
  assign bus.host_oe = oe;
  assign bus.addr_host = addr_q;
  assign bus.as_n_host = as_n;
  assign bus.rw_host = rw_q;
  assign bus.uds_n_host = ~be_q[1];
  assign bus.lds_n_host = ~be_q[0];
  assign bus.data_host = wdata_q;
  assign bus.data_host_oe = oe & ~rw_q & ~as_n;
  assign bus.wait_n = i_wait_n;
  assign bus.irq_n = i_irq_n;
  assign bus.high_impedance_select = i_hiz_sel;
  assign bus.test = i_test & ~i_hiz_sel;
endmodule : sbm_host
`default_nettype wire

// ==== verification/sbm_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbm_sva (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic high_impedance_select,
  input wire logic test,
  input wire logic out_oe,
  input wire logic addr_dev_oe_hi,
  input wire logic as_dev_oe,
  input wire logic rw_dev_oe,
  input wire logic br_n,
  input wire logic bg_n,
  input wire logic as_n,
  input wire logic rw,
  input wire logic rd_n,
  input wire logic wru_n,
  input wire logic wrl_n,
  input wire logic ext_ack_n
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  property p_off;
    (!high_impedance_select && !test)[*2]
      |-> !out_oe && !addr_dev_oe_hi && !as_dev_oe;
  endproperty
  a_off: assert property (p_off) else $error("pins not released");
  property p_inmode;
    (!high_impedance_select && test)[*2] |-> out_oe && !addr_dev_oe_hi;
  endproperty
  a_inmode: assert property (p_inmode) else $error("input mode");
  property p_norm;
    (high_impedance_select && !test && bg_n)[*2] |-> addr_dev_oe_hi;
  endproperty
  a_norm: assert property (p_norm) else $error("upper addr off");
  property p_grant;
    $fell(bg_n) |-> $past(as_n) && !$past(br_n);
  endproperty
  a_grant: assert property (p_grant) else $error("early grant");
  property p_hold;
    !bg_n && !br_n |=> !bg_n;
  endproperty
  a_hold: assert property (p_hold) else $error("grant dropped");
  property p_rel;
    !bg_n && !$past(bg_n) |-> !as_dev_oe && !rw_dev_oe;
  endproperty
  a_rel: assert property (p_rel) else $error("strobe driven");
  property p_ack;
    $fell(ext_ack_n) |-> !bg_n && !as_n;
  endproperty
  a_ack: assert property (p_ack) else $error("stray ack");
  property p_ackst;
    !ext_ack_n && !as_n |=> !ext_ack_n;
  endproperty
  a_ackst: assert property (p_ackst) else $error("ack lost");
  property p_rd;
    !rd_n |-> $past(rw);
  endproperty
  a_rd: assert property (p_rd) else $error("read strobe");
  property p_wu;
    !wru_n |-> !$past(rw);
  endproperty
  a_wu: assert property (p_wu) else $error("upper strobe");
  property p_wl;
    !wrl_n |-> !$past(rw);
  endproperty
  a_wl: assert property (p_wl) else $error("lower strobe");
endmodule : sbm_sva
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sbm_defs.svh"
module tb_top;
  logic clk = 1'b0, rstn = 1'b0, src_n = 1'b0, req = 1'b0, rrw = 1'b0;
  logic hiz = 1'b1, tst = 1'b0, wt_n = 1'b1, hst = 1'b0, hrw = 1'b0;
  logic [1:0] be = 2'h3, hbe = 2'h3, lv = 2'h0, irq = 2'h1, pend, ebe, cbe;
  logic [`SBM_ADDR_W-1:0] ad = '0, had = '0, ead, cad;
  logic [`SBM_DATA_W-1:0] hwd = '0, erd = '0, rdat, hrd, ewd, cwd;
  logic [3:0] cw = 4'h0;
  logic done, hdone, ph, em, ewr, hbusy, s_rd, s_wu, s_wl, s_cs, s_em;
  int num_errors = 0, cmp_count = 0, n_as = 0;
  sbm_if bus ();
  always #12.5 clk = ~clk;
  sbm_device sbm_device_i (.i_core_clk(clk), .i_resetn(rstn), .bus(bus.dev),
    .i_req(req), .i_req_rw(rrw), .i_req_addr(ad), .i_req_be(be),
    .i_req_wdata(16'hc35a), .o_req_done(done), .o_req_rdata(rdat),
    .i_cs_en(8'h01), .i_cs_base(64'h0), .i_cs_mask({56'h0, 8'hf0}),
    .i_cs_wait({28'h0, cw}), .i_irq_level(lv), .o_irq_pending(pend),
    .o_half_rate_en(ph), .o_ext_master(em), .o_ext_addr(ead),
    .o_ext_be(ebe), .o_ext_wdata(ewd), .o_ext_wr(ewr), .i_ext_rdata(erd));
  sbm_host sbm_host_i (.i_core_clk(clk), .i_resetn(rstn), .bus(bus.host),
    .i_reset_source_n(src_n), .i_hiz_sel(hiz), .i_test(tst),
    .i_wait_n(wt_n), .i_irq_n(irq), .i_start(hst), .i_rw(hrw),
    .i_addr(had), .i_be(hbe), .i_wdata(hwd), .o_busy(hbusy),
    .o_done(hdone), .o_rdata(hrd));
  sbm_sva sbm_sva_i (.i_core_clk(clk), .i_resetn(rstn),
    .high_impedance_select(bus.high_impedance_select), .test(bus.test),
    .out_oe(bus.out_oe), .addr_dev_oe_hi(bus.addr_dev_oe_hi),
    .as_dev_oe(bus.as_dev_oe), .rw_dev_oe(bus.rw_dev_oe),
    .br_n(bus.br_n), .bg_n(bus.bg_n), .as_n(bus.as_n), .rw(bus.rw),
    .rd_n(bus.rd_n), .wru_n(bus.wru_n), .wrl_n(bus.wrl_n),
    .ext_ack_n(bus.ext_ack_n));
  // sticky pin activity seen during the current transfer
  always @(posedge clk) begin
    if (bus.rd_n === 1'b0) s_rd <= 1'b1;
    if (bus.wru_n === 1'b0) s_wu <= 1'b1;
    if (bus.wrl_n === 1'b0) s_wl <= 1'b1;
    if (bus.cs_n[0] === 1'b0) s_cs <= 1'b1;
    if (em === 1'b1) s_em <= 1'b1;
    if (bus.as_n === 1'b0) n_as <= n_as + 1;
    if (ewr === 1'b1) begin
      cwd <= ewd;
      cad <= ead;
      cbe <= ebe;
    end
  end
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (s !== 1'b1 && n < 400);
    if (s !== 1'b1) begin
      num_errors++;
      results();
    end
  endtask : wait_hi
  task automatic clr();
    {s_rd, s_wu, s_wl, s_cs, s_em} = '0;
    n_as = 0;
  endtask : clr
  // returns the number of clocks the address strobe stayed low
  task automatic dev_op(input logic r, input logic [24:0] a,
                        input logic [1:0] b, output int l);
    @(posedge clk);
    clr();
    rrw <= r;
    ad <= a;
    be <= b;
    req <= 1'b1;
    wait_hi(done);
    req <= 1'b0;
    @(posedge clk);
    l = n_as;
  endtask : dev_op
  task automatic host_op(input logic r, input logic [1:0] b);
    @(posedge clk);
    clr();
    hrw <= r;
    had <= 25'h000200;
    hbe <= b;
    hwd <= 16'hbeef;
    hst <= 1'b1;
    @(posedge clk);
    hst <= 1'b0;
    @(posedge clk);
    chk("busy", 1, hbusy);
    wait_hi(hdone);
    repeat (3) @(posedge clk);
    chk("idle", 0, hbusy);
  endtask : host_op
  task automatic t_phase();
    logic p;
    @(posedge clk);
    src_n <= 1'b0;
    repeat (3) @(posedge clk);
    p = ph;
    // odd count puts the free-running phase opposite to the realigned one
    repeat (7) begin
      @(posedge clk);
      chk("phase", !p, ph);
      p = ph;
    end
    src_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("align", 0, ph);
    chk("align_clk", 0, bus.half_rate_clock);
    p = ph;
    @(posedge clk);
    chk("phase", !p, ph);
    $display("t_phase finished");
  endtask : t_phase
  task automatic t_lanes();
    int l;
    for (int i = 1; i < 4; i++) begin
      dev_op(1'b0, 25'h000100, i[1:0], l);
      chk("wru", i[1], s_wu);
      chk("wrl", i[0], s_wl);
      chk("rd", 0, s_rd);
      chk("cs", 1, s_cs);
    end
    dev_op(1'b1, 25'h000100, 2'h3, l);
    chk("rd", 1, s_rd);
    chk("wr", 0, s_wu | s_wl);
    chk("rdata", 16'hffff, rdat);
    dev_op(1'b1, 25'h1000100, 2'h3, l);
    chk("cs", 0, s_cs);
    $display("t_lanes finished");
  endtask : t_lanes
  task automatic t_wait();
    int l0, l;
    dev_op(1'b1, 25'h000100, 2'h3, l0);
    cw <= 4'h2;
    dev_op(1'b1, 25'h000100, 2'h3, l);
    chk("wait2", l0 + 4, l);
    cw <= 4'h0;
    wt_n <= 1'b0;
    dev_op(1'b1, 25'h1000100, 2'h3, l);
    chk("nocs", l0, l);
    fork
      begin
        repeat (12) @(posedge clk);
        wt_n <= 1'b1;
      end
    join_none
    dev_op(1'b1, 25'h000100, 2'h3, l);
    chk("stretch", 1, l > l0 + 6);
    $display("t_wait finished");
  endtask : t_wait
  task automatic t_ext();
    erd <= 16'h5a3c;
    host_op(1'b0, 2'h2);
    chk("ewdata", 16'hbeef, cwd);
    chk("eaddr", 25'h000200, cad);
    chk("ebe", 2'h2, cbe);
    chk("wru", 1, s_wu);
    chk("wrl", 0, s_wl);
    chk("cs", 1, s_cs);
    chk("grant", 1, s_em);
    host_op(1'b1, 2'h3);
    chk("hrdata", 16'h5a3c, hrd);
    chk("rd", 1, s_rd);
    chk("bg", 1, bus.bg_n);
    $display("t_ext finished");
  endtask : t_ext
  // own read taken just before the request; grant must wait for its end
  task automatic t_arb();
    int l;
    @(posedge clk);
    if (ph !== 1'b1) @(posedge clk);
    erd <= 16'h0f1e;
    fork
      dev_op(1'b1, 25'h000100, 2'h3, l);
      host_op(1'b1, 2'h3);
    join
    chk("arb_as", 4, l);
    chk("arb_hrd", 16'h0f1e, hrd);
    $display("t_arb finished");
  endtask : t_arb
  task automatic t_pins();
    for (int m = 0; m < 3; m++) begin
      @(posedge clk);
      hiz <= m[1];
      tst <= m[0];
      repeat (3) @(posedge clk);
      chk("addr_hi_oe", m[1], bus.addr_dev_oe_hi);
      chk("out_oe", m != 0, bus.out_oe);
    end
    $display("t_pins finished");
  endtask : t_pins
  task automatic t_irq();
    logic [1:0] e;
    for (int v = 1; v < 3; v++) begin
      @(posedge clk);
      lv <= v[1:0];
      e = ~(v[1:0] ^ 2'h1);
      repeat (4) @(posedge clk);
      chk("irq", e, pend);
    end
    $display("t_irq finished");
  endtask : t_irq
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    src_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_phase();
    t_lanes();
    t_wait();
    t_ext();
    t_arb();
    t_pins();
    t_irq();
    results();
  end
endmodule : tb_top
`default_nettype wire
